// file: hw/mac_tx_pkg.sv
// Shared modes, lane layouts and timing constants for the host transmit port
package mac_tx_pkg;

	// Gray order along MII -> RMII -> RGMII -> GMII
	typedef enum logic [1:0] {
		MODE_MII = 2'h0,
		MODE_RMII = 2'h1,
		MODE_RGMII = 2'h3,
		MODE_GMII = 2'h2
	} if_mode_e;

	localparam int BYTE_W = 8;
	localparam int NIB_W = 4;
	localparam int DIBIT_W = 2;
	localparam int SYNC_STAGES = 2;
	localparam logic [7:0] MASK_BYTE = 8'hff;
	localparam logic [7:0] MASK_NIB = 8'h0f;
	localparam logic [7:0] MASK_DIBIT = 8'h03;
	localparam logic [1:0] LAST_BYTE = 2'h0;
	localparam logic [1:0] LAST_NIB = 2'h1;
	localparam logic [1:0] LAST_DIBIT = 2'h3;

	localparam int unsigned SYS_CLK_HZ = 40_000_000;
	// Line clock made from the 40 MHz clock; of the nominal rates only 2.5 MHz is an integer division of it
	localparam int unsigned LINE_CLK_HZ = 10_000_000;
	localparam int CLK_HALF_CYC = SYS_CLK_HZ / (2 * LINE_CLK_HZ);
	// Line periods for which the line-domain reset is held after srst_i falls
	localparam int LRST_LINE_CYC = 6;

	function automatic logic [7:0] lane_mask(input if_mode_e m);
		case (m)
			MODE_GMII: lane_mask = MASK_BYTE;
			MODE_RMII: lane_mask = MASK_DIBIT;
			default: lane_mask = MASK_NIB;
		endcase
	endfunction

	function automatic logic [1:0] beat_last(input if_mode_e m);
		case (m)
			MODE_GMII: beat_last = LAST_BYTE;
			MODE_RMII: beat_last = LAST_DIBIT;
			default: beat_last = LAST_NIB;
		endcase
	endfunction

	function automatic int beat_width(input if_mode_e m);
		case (m)
			MODE_GMII: beat_width = BYTE_W;
			MODE_RMII: beat_width = DIBIT_W;
			default: beat_width = NIB_W;
		endcase
	endfunction

	function automatic logic has_err_col(input if_mode_e m);
		has_err_col = (m == MODE_MII) || (m == MODE_GMII);
	endfunction

endpackage

// file: hw/host_tx_if.sv
// Pins between the host transmit port and its partner, with shared-pin resolution
`timescale 1ns/10ps
interface host_tx_if;
	logic dev_clk_out;
	logic dev_clk_oe;
	logic host_clk_out;
	logic host_clk_oe;
	logic ref_clk_out;
	logic ref_clk_oe;
	logic host_tx_clock;
	logic link_clock;
	logic host_tx_enable;
	logic host_tx_error;
	logic [7:0] host_tx_data;
	logic dev_col_out;
	logic dev_col_oe;
	logic host_col_out;
	logic host_col_oe;
	logic host_collision;

	assign host_tx_clock = dev_clk_oe ? dev_clk_out : (host_clk_oe ? host_clk_out : 1'b0);
	// In the self-clocked reduced mode the device's own reference clocks the line
	assign link_clock = ref_clk_oe ? ref_clk_out : host_tx_clock;
	assign host_collision = dev_col_oe ? dev_col_out : (host_col_oe ? host_col_out : 1'b0);

	modport device (
		input link_clock,
		output dev_clk_out,
		output dev_clk_oe,
		output ref_clk_out,
		output ref_clk_oe,
		input host_tx_enable,
		input host_tx_error,
		input host_tx_data,
		output dev_col_out,
		output dev_col_oe,
		input host_collision
	);

	modport host (
		input link_clock,
		output host_clk_out,
		output host_clk_oe,
		output host_tx_enable,
		output host_tx_error,
		output host_tx_data,
		output host_col_out,
		output host_col_oe,
		input host_collision
	);
endinterface

// file: hw/lane_packer.sv
// Packs line beats of one, two or four slices into bytes, low slice first
`timescale 1ns/10ps
module lane_packer import mac_tx_pkg::*; (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	input wire logic valid_i,
	input wire logic [7:0] slice_i,
	input wire logic err_i,
	input wire logic [1:0] last_i,
	output logic valid_o,
	output logic [7:0] byte_o,
	output logic err_o
);
	logic [7:0] acc;
	logic [7:0] next_acc;
	logic [1:0] beat;
	logic err_acc;

	always_comb begin
		case (last_i)
			LAST_BYTE: next_acc = slice_i;
			LAST_NIB: next_acc = {slice_i[NIB_W-1:0], acc[BYTE_W-1:NIB_W]};
			default: next_acc = {slice_i[DIBIT_W-1:0], acc[BYTE_W-1:DIBIT_W]};
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			acc <= 8'h00;
			beat <= 2'h0;
			err_acc <= 1'b0;
		end else if (ce_i) begin
			if (!valid_i) begin
				// A partial byte at frame end is dropped
				beat <= 2'h0;
				err_acc <= 1'b0;
			end else if (beat == last_i) begin
				acc <= next_acc;
				beat <= 2'h0;
				err_acc <= 1'b0;
			end else begin
				acc <= next_acc;
				beat <= beat + 2'h1;
				err_acc <= err_acc | err_i;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			valid_o <= 1'b0;
			byte_o <= 8'h00;
			err_o <= 1'b0;
		end else if (ce_i) begin
			valid_o <= valid_i && (beat == last_i);
			if (valid_i && (beat == last_i)) begin
				byte_o <= next_acc;
				err_o <= err_acc | err_i;
			end
		end
	end
endmodule

// file: hw/mac_tx_host.sv
// Partner end: turns a byte stream into line beats and supplies the line clock except in MII with the device as PHY and in RMII clock mode
`timescale 1ns/10ps
module mac_tx_host import mac_tx_pkg::*; #(
	parameter int CLK_HALF = CLK_HALF_CYC
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	input wire if_mode_e mode_i,
	input wire logic dev_phy_role_i,
	input wire logic rmii_clock_mode_i,
	host_tx_if.host link,
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	input wire logic tx_error_i,
	output logic tx_ready_o,
	input wire logic collision_i,
	output logic collision_o
);
	typedef enum logic {ST_IDLE = 1'b0, ST_SEND = 1'b1} send_state_e;

	send_state_e state;
	logic self_clk;
	logic [7:0] div_cnt;
	logic div_clk;
	logic own_fall;
	logic [SYNC_STAGES:0] lclk_sync;
	logic ext_fall;
	logic tick;
	logic [1:0] beat;
	logic [7:0] shreg;
	logic err_q;
	logic [SYNC_STAGES-1:0] col_sync;

	// [RL1] [RL2] [RL3] [RL4]
	assign self_clk = !(((mode_i == MODE_MII) && dev_phy_role_i) || ((mode_i == MODE_RMII) && rmii_clock_mode_i));

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			div_cnt <= 8'h00;
			div_clk <= 1'b0;
		end else if (ce_i) begin
			if (div_cnt == 8'(CLK_HALF - 1)) begin
				div_cnt <= 8'h00;
				div_clk <= !div_clk;
			end else begin
				div_cnt <= div_cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			link.host_clk_out <= 1'b0;
			link.host_clk_oe <= 1'b0;
		end else if (ce_i) begin
			link.host_clk_out <= div_clk;
			link.host_clk_oe <= self_clk; // [RL3] [RL4]
		end
	end

	// A clock made by the device is sampled; its beats must be far slower than clk_i
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			lclk_sync <= '0;
		end else if (ce_i) begin
			lclk_sync <= {lclk_sync[SYNC_STAGES-1:0], link.link_clock};
		end
	end

	assign own_fall = div_clk && (div_cnt == 8'(CLK_HALF - 1));
	assign ext_fall = lclk_sync[SYNC_STAGES] && !lclk_sync[SYNC_STAGES-1];
	assign tick = self_clk ? own_fall : ext_fall;
	assign tx_ready_o = ce_i && tick && ((state == ST_IDLE) || (beat == beat_last(mode_i)));

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state <= ST_IDLE;
			beat <= 2'h0;
			shreg <= 8'h00;
			err_q <= 1'b0;
			link.host_tx_enable <= 1'b0;
			link.host_tx_error <= 1'b0;
			link.host_tx_data <= 8'h00;
		end else if (ce_i && tick) begin
			if (tx_ready_o && tx_valid_i) begin
				state <= ST_SEND;
				beat <= 2'h0;
				shreg <= 8'(tx_data_i >> beat_width(mode_i));
				err_q <= tx_error_i;
				link.host_tx_enable <= 1'b1; // [RL5]
				link.host_tx_error <= tx_error_i && has_err_col(mode_i); // [RL6]
				link.host_tx_data <= tx_data_i & lane_mask(mode_i); // [RL8] [RL9] [RL10]
			end else if ((state == ST_SEND) && (beat != beat_last(mode_i))) begin
				beat <= beat + 2'h1;
				shreg <= 8'(shreg >> beat_width(mode_i));
				link.host_tx_error <= err_q && has_err_col(mode_i);
				link.host_tx_data <= shreg & lane_mask(mode_i);
			end else begin
				state <= ST_IDLE;
				beat <= 2'h0;
				link.host_tx_enable <= 1'b0;
				link.host_tx_error <= 1'b0;
				link.host_tx_data <= 8'h00;
			end
		end
	end

	// Host plays the line-side party for collision when the device is the MAC
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			link.host_col_out <= 1'b0;
			link.host_col_oe <= 1'b0;
			col_sync <= '0;
			collision_o <= 1'b0;
		end else if (ce_i) begin
			link.host_col_out <= collision_i;
			link.host_col_oe <= !dev_phy_role_i && has_err_col(mode_i); // [RL7]
			col_sync <= {col_sync[SYNC_STAGES-2:0], link.host_collision};
			collision_o <= col_sync[SYNC_STAGES-1] && dev_phy_role_i && has_err_col(mode_i); // [RL7]
		end
	end
endmodule

// file: hw/mac_tx_device.sv
// Switch end of the host transmit port: mode routing, line capture, byte hand-over
// Port rules; the line clock is 10 MHz in all modes and RGMII control is read single-rate
// RL1: MII clock 25/2.5 MHz, driven as PHY
// RL2: RMII normal takes 50 MHz reference; clock-mode leaves pin
// RL3: GMII partner supplies 125 MHz transmit clock
// RL4: RGMII partner supplies speed-matched transmit clock
// RL5: Qualifier is enable, or control in RGMII
// RL6: Transmit error only in MII and GMII
// RL7: Collision only MII/GMII; PHY drives, MAC samples
// RL8: Data bits 7..4 only in GMII
// RL9: Data bits 3..2 in all but RMII
// RL10: Data bits 1..0 in every mode
// RL11: Unused inputs never affect received frames
// RL12: Mode, role and RMII clock selection route pins
`timescale 1ns/10ps
module mac_tx_device import mac_tx_pkg::*; #(
	parameter int CLK_HALF = CLK_HALF_CYC
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	input wire if_mode_e mode_i,
	input wire logic phy_role_i,
	input wire logic rmii_clock_mode_i,
	host_tx_if.device link,
	input wire logic collision_i,
	output logic collision_o,
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	output logic rx_error_o,
	output logic rx_end_o
);
	localparam int CFG_W = 6;
	localparam int CFG_RST = 5;
	localparam int CFG_CE = 4;
	localparam int EV_W = 10;
	localparam int EV_END = 9;
	localparam int EV_ERR = 8;

	logic [7:0] div_cnt;
	logic div_clk;
	logic [SYNC_STAGES-1:0] col_sync;
	logic [7:0] lrst_hold;
	logic lrst_req;

	logic [CFG_W-1:0] cfg_s1;
	logic [CFG_W-1:0] cfg_s2;
	logic lrst;
	logic lce;
	if_mode_e lmode;
	logic en_q;
	logic en_prev;
	logic en_prev2;
	logic er_q;
	logic [7:0] d_q;
	logic pk_valid;
	logic [7:0] pk_byte;
	logic pk_err;
	logic [EV_W-1:0] ev_word;
	logic ev_tog;

	logic [SYNC_STAGES:0] tog_sync;
	logic ev_seen;

	// System domain: clock generation and pin direction control

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			div_cnt <= 8'h00;
			div_clk <= 1'b0;
		end else if (ce_i) begin
			if (div_cnt == 8'(CLK_HALF - 1)) begin
				div_cnt <= 8'h00;
				div_clk <= !div_clk;
			end else begin
				div_cnt <= div_cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			link.dev_clk_out <= 1'b0;
			link.dev_clk_oe <= 1'b0;
			link.ref_clk_out <= 1'b0;
			link.ref_clk_oe <= 1'b0;
		end else if (ce_i) begin
			link.dev_clk_out <= div_clk;
			link.dev_clk_oe <= (mode_i == MODE_MII) && phy_role_i; // [RL1] [RL12]
			link.ref_clk_out <= div_clk;
			// Transmit clock pin stays an input otherwise; reference leaves on its own pin
			link.ref_clk_oe <= (mode_i == MODE_RMII) && rmii_clock_mode_i; // [RL2] [RL12]
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			link.dev_col_out <= 1'b0;
			link.dev_col_oe <= 1'b0;
		end else if (ce_i) begin
			link.dev_col_out <= collision_i && has_err_col(mode_i);
			link.dev_col_oe <= phy_role_i && has_err_col(mode_i); // [RL7]
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			col_sync <= '0;
			collision_o <= 1'b0;
		end else if (ce_i) begin
			col_sync <= {col_sync[SYNC_STAGES-2:0], link.host_collision};
			// Sampled only as MAC and only where the pin exists
			collision_o <= col_sync[SYNC_STAGES-1] && !phy_role_i && has_err_col(mode_i); // [RL7] [RL11]
		end
	end

	// Line clocks stand low during srst_i, so the line domain can only take its reset
	// while this hold runs after release; it spans several line periods
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			lrst_hold <= 8'(LRST_LINE_CYC * (CLK_HALF + CLK_HALF));
			lrst_req <= 1'b1;
		end else if (ce_i) begin
			lrst_req <= (lrst_hold != 8'h00);
			if (lrst_hold != 8'h00) begin
				lrst_hold <= lrst_hold - 8'h01;
			end
		end
	end

	// Line domain: settings and reset cross as static levels

	always_ff @(posedge link.link_clock) begin
		cfg_s1 <= {lrst_req, ce_i, mode_i, phy_role_i, rmii_clock_mode_i};
		cfg_s2 <= cfg_s1;
	end

	assign lrst = cfg_s2[CFG_RST];
	assign lce = cfg_s2[CFG_CE];
	assign lmode = if_mode_e'(cfg_s2[CFG_CE-1:CFG_CE-2]);

	// Pins arrive with the line clock, so they are captured without a synchroniser
	always_ff @(posedge link.link_clock) begin
		if (lrst) begin
			en_q <= 1'b0;
			en_prev <= 1'b0;
			en_prev2 <= 1'b0;
			er_q <= 1'b0;
			d_q <= 8'h00;
		end else if (lce) begin
			// Single-rate capture of the control pin; the second-edge error half is not decoded
			en_q <= link.host_tx_enable; // [RL5]
			en_prev <= en_q;
			en_prev2 <= en_prev;
			er_q <= link.host_tx_error && has_err_col(lmode); // [RL6] [RL11]
			d_q <= link.host_tx_data & lane_mask(lmode); // [RL8] [RL9] [RL10] [RL11]
		end
	end

	lane_packer u_packer (
		.clk_i(link.link_clock),
		.srst_i(lrst),
		.ce_i(lce),
		.valid_i(en_q),
		.slice_i(d_q),
		.err_i(er_q),
		.last_i(beat_last(lmode)), // [RL12]
		.valid_o(pk_valid),
		.byte_o(pk_byte),
		.err_o(pk_err)
	);

	// Each byte or frame end flips the toggle; the word holds until the next event
	always_ff @(posedge link.link_clock) begin
		if (lrst) begin
			ev_word <= '0;
			ev_tog <= 1'b0;
		end else if (lce) begin
			if (pk_valid) begin
				ev_word <= {1'b0, pk_err, pk_byte};
				ev_tog <= !ev_tog;
			// Frame end is taken one line edge after the packer's last byte, so the two never collide
			end else if (en_prev2 && !en_prev) begin
				ev_word <= {1'b1, 1'b0, 8'h00};
				ev_tog <= !ev_tog;
			end
		end
	end

	// Back in the system domain

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			tog_sync <= '0;
		end else if (ce_i) begin
			tog_sync <= {tog_sync[SYNC_STAGES-1:0], ev_tog};
		end
	end

	assign ev_seen = tog_sync[SYNC_STAGES] ^ tog_sync[SYNC_STAGES-1];

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rx_valid_o <= 1'b0;
			rx_end_o <= 1'b0;
			rx_data_o <= 8'h00;
			rx_error_o <= 1'b0;
		end else if (ce_i) begin
			rx_valid_o <= ev_seen && !ev_word[EV_END];
			rx_end_o <= ev_seen && ev_word[EV_END];
			if (ev_seen) begin
				rx_data_o <= ev_word[7:0];
				rx_error_o <= ev_word[EV_ERR];
			end
		end
	end
endmodule

// file: testbench/host_tx_sva.sv
// Pin direction and lane-use checks on the host transmit port
`timescale 1ns/10ps
module host_tx_sva import mac_tx_pkg::*; (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire if_mode_e mode_i,
	input wire logic phy_role_i,
	input wire logic rmii_clock_mode_i,
	input wire logic dev_clk_oe,
	input wire logic host_clk_oe,
	input wire logic ref_clk_oe,
	input wire logic link_clock,
	input wire logic host_tx_enable,
	input wire logic host_tx_error,
	input wire logic [7:0] host_tx_data,
	input wire logic dev_col_oe,
	input wire logic host_col_oe
);
	logic [2:0] settle;
	logic ok;
	logic err_col;

	// Enables are registered, so give them a few cycles after reset to settle
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			settle <= 3'h0;
		end else if (settle != 3'h7) begin
			settle <= settle + 3'h1;
		end
	end
	assign ok = (settle == 3'h7);
	assign err_col = (mode_i == MODE_MII) || (mode_i == MODE_GMII);

	default clocking @(posedge clk_i);
	endclocking
	default disable iff (srst_i);

	a_mii_clk_dir: assert property (ok && mode_i == MODE_MII |->
		dev_clk_oe == phy_role_i && host_clk_oe == !phy_role_i) else $error("tx clock direction wrong in MII");
	a_rmii_ref_src: assert property (ok && mode_i == MODE_RMII |->
		ref_clk_oe == rmii_clock_mode_i && !dev_clk_oe && host_clk_oe == !rmii_clock_mode_i)
		else $error("reference clock source wrong in RMII");
	a_gig_clk_in: assert property (ok && mode_i inside {MODE_GMII, MODE_RGMII} |->
		host_clk_oe && !dev_clk_oe && !ref_clk_oe) else $error("partner does not supply tx clock");
	a_col_dir: assert property (ok |-> dev_col_oe == (err_col && phy_role_i) &&
		host_col_oe == (err_col && !phy_role_i)) else $error("collision pin driver wrong");
	a_err_unused: assert property (ok && !err_col |-> !host_tx_error)
		else $error("tx error driven in reduced mode");
	a_upper_lanes: assert property (ok && mode_i != MODE_GMII |-> host_tx_data[7:4] == 4'h0)
		else $error("upper data lanes driven outside GMII");
	a_mid_lanes: assert property (ok && mode_i == MODE_RMII |-> host_tx_data[3:2] == 2'h0)
		else $error("middle data lanes driven in RMII");
	a_line_clk_runs: assert property (ok && $rose(host_tx_enable) |-> ##[1:16] $rose(link_clock))
		else $error("line clock idle during frame");

	c_rmii_self: cover property (ok && mode_i == MODE_RMII && rmii_clock_mode_i && host_tx_enable);
	c_gmii_frame: cover property (ok && mode_i == MODE_GMII && host_tx_enable);
	c_mii_phy_col: cover property (ok && mode_i == MODE_MII && dev_col_oe);
endmodule

// file: testbench/port6_mac_tx_pin_mapping_tb_top.sv
// Frames through both ends of the host transmit port in every mode
`timescale 1ns/10ps
module port6_mac_tx_pin_mapping_tb_top import mac_tx_pkg::*; ;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic ce_i = 1'b1;
	if_mode_e mode = MODE_MII;
	logic phy_role = 1'b0;
	logic rmii_ck = 1'b0;
	logic tx_valid = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic tx_error = 1'b0;
	logic tx_ready;
	logic dev_col_in = 1'b0;
	logic host_col_in = 1'b0;
	logic dev_col_out, host_col_out, rx_valid, rx_error, rx_end;
	logic [7:0] rx_data;
	logic [8:0] rx_q[$];
	int n_end;
	int mismatches = 0;
	int n_tests = 0;
	if_mode_e modes[6] = '{MODE_MII, MODE_MII, MODE_RMII, MODE_RMII, MODE_GMII, MODE_RGMII};
	logic phys[6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
	logic rcks[6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
	logic [7:0] frame[4] = '{8'ha5, 8'h3c, 8'he1, 8'h5a};

	host_tx_if link_if();

	mac_tx_host u_mac_tx_host (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .mode_i(mode),
		.dev_phy_role_i(phy_role), .rmii_clock_mode_i(rmii_ck), .link(link_if.host),
		.tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_error_i(tx_error), .tx_ready_o(tx_ready),
		.collision_i(host_col_in), .collision_o(host_col_out));

	mac_tx_device u_mac_tx_device (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .mode_i(mode),
		.phy_role_i(phy_role), .rmii_clock_mode_i(rmii_ck), .link(link_if.device),
		.collision_i(dev_col_in), .collision_o(dev_col_out), .rx_valid_o(rx_valid),
		.rx_data_o(rx_data), .rx_error_o(rx_error), .rx_end_o(rx_end));

	host_tx_sva u_host_tx_sva (.clk_i(clk_i), .srst_i(srst_i), .mode_i(mode), .phy_role_i(phy_role),
		.rmii_clock_mode_i(rmii_ck), .dev_clk_oe(link_if.dev_clk_oe), .host_clk_oe(link_if.host_clk_oe),
		.ref_clk_oe(link_if.ref_clk_oe), .link_clock(link_if.link_clock),
		.host_tx_enable(link_if.host_tx_enable), .host_tx_error(link_if.host_tx_error),
		.host_tx_data(link_if.host_tx_data), .dev_col_oe(link_if.dev_col_oe),
		.host_col_oe(link_if.host_col_oe));

	always #12.5 clk_i = ~clk_i;

	always @(posedge clk_i) begin
		if (rx_valid === 1'b1)
			rx_q.push_back({rx_error, rx_data});
		if (rx_end === 1'b1)
			n_end++;
	end

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check1(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Mode pins are static, so every configuration gets its own reset
	task automatic do_reset(input int s);
		@(posedge clk_i);
		#2;
		srst_i = 1'b1;
		mode = modes[s];
		phy_role = phys[s];
		rmii_ck = rcks[s];
		dev_col_in = 1'b0;
		host_col_in = 1'b0;
		repeat (2) @(posedge clk_i);
		#2;
		srst_i = 1'b0;
		repeat (60) @(posedge clk_i);
		#2;
	endtask

	task automatic send_byte(input logic [7:0] d, input logic e);
		int i;
		tx_valid = 1'b1;
		tx_data = d;
		tx_error = e;
		for (i = 0; i < 400; i++) begin
			@(posedge clk_i);
			if (tx_ready === 1'b1)
				break;
		end
		if (i == 400) begin
			mismatches++;
			test_done();
		end
		#2;
	endtask

	initial begin
		int s, b, i;
		logic has;
		for (s = 0; s < 6; s++) begin
			do_reset(s);
			has = (modes[s] == MODE_MII) || (modes[s] == MODE_GMII);
			rx_q.delete();
			n_end = 0;
			// Error flagged on the second byte in every mode; reduced modes must drop it
			for (b = 0; b < 4; b++)
				send_byte(frame[b], b == 1);
			tx_valid = 1'b0;
			for (i = 0; i < 600 && n_end == 0; i++)
				@(posedge clk_i);
			if (n_end == 0) begin
				mismatches++;
				test_done();
			end
			#2;
			dev_col_in = 1'b1;
			host_col_in = 1'b1;
			repeat (12) @(posedge clk_i);
			check8(8'(rx_q.size()), 8'h04);
			for (b = 0; b < 4; b++) begin
				check8(rx_q[b][7:0], frame[b]);
				check1(rx_q[b][8], has && b == 1);
			end
			check1(n_end == 1, 1'b1);
			check1(dev_col_out, has && !phys[s]);
			check1(host_col_out, has && phys[s]);
		end
		test_done();
	end
endmodule
